/* pkg/ibl_params.svh */
// Constants for the initiator bandwidth limiter.
// Assumes inclusion by bare name from the package and the design.
`ifndef IBL_PARAMS_SVH
`define IBL_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IBL_OFS_FRAC   16'h5208
`define IBL_OFS_WHOLE  16'h520c
`define IBL_OFS_PEAK   16'h5210
`define IBL_OFS_STAT   16'h5214

// ----------------------------------------
// Field widths and reset values
// ----------------------------------------
`define IBL_FRAC_W     5
`define IBL_WHOLE_W    4
`define IBL_PEAK_W     11
`define IBL_FRAC_RST   5'h00
`define IBL_WHOLE_RST  4'h1
`define IBL_PEAK_RST   11'h7ff

// ----------------------------------------
// Budget arithmetic and bus answers
// ----------------------------------------
`define IBL_SUB_BITS   5
`define IBL_CRED_W     22
`define IBL_RESP_OKAY  2'h0
`define IBL_RESP_SLV   2'h2

`endif

/* pkg/ibl_pkg.sv */
// Types for the initiator bandwidth limiter.
// Assumes ibl_params.svh is on the include path.
`include "ibl_params.svh"

package ibl_pkg;

  // ----------------------------------------
  // Register selection
  // ----------------------------------------
  typedef enum logic [2:0] {
    IBL_SEL_NONE,
    IBL_SEL_FRAC,
    IBL_SEL_WHOLE,
    IBL_SEL_PEAK,
    IBL_SEL_STAT
  } ibl_sel_t;

  // ----------------------------------------
  // Write channel state
  // ----------------------------------------
  typedef enum logic {
    IBL_WR_COLLECT,
    IBL_WR_RESP
  } ibl_wr_state_t;

  typedef logic signed [`IBL_CRED_W-1:0] ibl_cred_t;

endpackage

/* verilog/ibl_limiter.sv */
// Bandwidth limiter for one processor initiator, AXI4-Lite registers.
// Assumes initiator, memory path and bus master share i_mclk.
`timescale 1ns/100ps
`include "ibl_params.svh"

module ibl_limiter
  import ibl_pkg::*;
#(
  parameter int ADDR_W      = 16,
  parameter int REQ_ADDR_W  = 32,
  parameter int BYTES_W     = 8,
  parameter int BURST_BYTES = 64
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]     i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [ADDR_W-1:0]     i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  // Initiator request side
  input  wire logic                  i_req_valid,
  input  wire logic [REQ_ADDR_W-1:0] i_req_addr,
  input  wire logic [BYTES_W-1:0]    i_req_bytes,
  output logic                       o_req_ready,
  // Memory path side
  output logic                       o_mem_valid,
  output logic [REQ_ADDR_W-1:0]      o_mem_addr,
  output logic [BYTES_W-1:0]         o_mem_bytes,
  input  wire logic                  i_mem_ready
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic ibl_sel_t sel_of(
    input logic [ADDR_W-1:0] addr
  );
    logic [15:0] a;
    a = addr[15:0];
    case (a)
      `IBL_OFS_FRAC:  sel_of = IBL_SEL_FRAC;
      `IBL_OFS_WHOLE: sel_of = IBL_SEL_WHOLE;
      `IBL_OFS_PEAK:  sel_of = IBL_SEL_PEAK;
      `IBL_OFS_STAT:  sel_of = IBL_SEL_STAT;
      default:        sel_of = IBL_SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [`IBL_FRAC_W-1:0]  frac_q;
  logic [`IBL_WHOLE_W-1:0] whole_q;
  logic [`IBL_PEAK_W-1:0]  peak_q;
  ibl_cred_t               cred_q;
  ibl_cred_t               cred_d;
  ibl_wr_state_t           wr_st_q;
  logic                    aw_have_q;
  logic                    w_have_q;
  logic [ADDR_W-1:0]       aw_addr_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic [31:0]             frac_wr;
  logic [31:0]             whole_wr;
  logic [31:0]             peak_wr;
  logic                    aw_take;
  logic                    w_take;
  logic                    ar_take;
  logic                    do_wr;
  ibl_sel_t                wr_sel;
  logic                    accept;
  logic                    mem_valid_d;

  assign aw_take = i_awvalid && o_awready;
  assign w_take  = i_wvalid && o_wready;
  assign ar_take = i_arvalid && o_arready;
  assign do_wr   = (wr_st_q == IBL_WR_COLLECT) && aw_have_q && w_have_q;
  assign wr_sel  = sel_of(aw_addr_q);
  assign accept  = i_req_valid && o_req_ready;

  // Lane-merged candidates; bits above each field are dropped below
  assign frac_wr  = merge({27'h0, frac_q}, w_data_q, w_strb_q);
  assign whole_wr = merge({28'h0, whole_q}, w_data_q, w_strb_q);
  assign peak_wr  = merge({21'h0, peak_q}, w_data_q, w_strb_q);

  // ----------------------------------------
  // Write address and data capture
  // ----------------------------------------
  // Each channel is held once; slave takes them in either order.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= i_awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      w_data_q <= i_wdata;
      w_strb_q <= i_wstrb;
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
    end else begin
      o_awready <= !(aw_take || (aw_have_q && !do_wr));
      o_wready  <= !(w_take || (w_have_q && !do_wr));
    end
  end

  // ----------------------------------------
  // Write response
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_st_q  <= IBL_WR_COLLECT;
      o_bvalid <= 1'b0;
      o_bresp  <= `IBL_RESP_OKAY;
    end else begin
      case (wr_st_q)
        IBL_WR_COLLECT: begin
          if (do_wr) begin
            wr_st_q  <= IBL_WR_RESP;
            o_bvalid <= 1'b1;
            o_bresp  <= (wr_sel == IBL_SEL_NONE) ?
                        `IBL_RESP_SLV : `IBL_RESP_OKAY;
          end
        end
        IBL_WR_RESP: begin
          if (i_bready) begin
            wr_st_q  <= IBL_WR_COLLECT;
            o_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_st_q  <= IBL_WR_COLLECT;
          o_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Status word is read-only; writes to it are accepted and dropped.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      frac_q  <= `IBL_FRAC_RST;
      whole_q <= `IBL_WHOLE_RST;
      peak_q  <= `IBL_PEAK_RST;
    end else if (do_wr) begin
      case (wr_sel)
        IBL_SEL_FRAC: begin
          frac_q <= frac_wr[`IBL_FRAC_W-1:0];
        end
        IBL_SEL_WHOLE: begin
          whole_q <= whole_wr[`IBL_WHOLE_W-1:0];
        end
        IBL_SEL_PEAK: begin
          peak_q <= peak_wr[`IBL_PEAK_W-1:0];
        end
        default: begin
          peak_q <= peak_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end else if (ar_take) begin
      o_rvalid  <= 1'b1;
      o_arready <= 1'b0;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Reserved bits read as zero
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
      o_rresp <= `IBL_RESP_OKAY;
    end else if (ar_take) begin
      o_rresp <= `IBL_RESP_OKAY;
      case (sel_of(i_araddr))
        IBL_SEL_FRAC:  o_rdata <= {27'h0, frac_q};
        IBL_SEL_WHOLE: o_rdata <= {28'h0, whole_q};
        IBL_SEL_PEAK:  o_rdata <= {21'h0, peak_q};
        IBL_SEL_STAT:  o_rdata <= {!o_req_ready, 9'h0, cred_q};
        default: begin
          o_rdata <= '0;
          o_rresp <= `IBL_RESP_SLV;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Byte budget
  // ----------------------------------------
  // Budget counts 1/32 byte, so the fractional rate adds exactly.
  ibl_cred_t rate;
  ibl_cred_t cap;
  ibl_cred_t take;
  ibl_cred_t sum;

  always_comb begin
    // Refill per clock: whole and fraction joined
    rate = ibl_cred_t'({whole_q, frac_q});
    // Zero allowance leaves only one burst of headroom
    cap  = ibl_cred_t'(BURST_BYTES);
    if (peak_q != '0) begin
      // Programmed value carries one extra
      cap = cap + ibl_cred_t'(peak_q - 11'h001);
    end
    cap  = cap <<< `IBL_SUB_BITS;
    take = accept ? (ibl_cred_t'(i_req_bytes) <<< `IBL_SUB_BITS) : '0;
    sum  = cred_q + rate - take;
    cred_d = (sum > cap) ? cap : sum;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cred_q <= '0;
    end else begin
      cred_q <= cred_d;
    end
  end

  // ----------------------------------------
  // Request forwarding
  // ----------------------------------------
  // One-entry slot; no new request while it is full. Costs a bubble
  // between requests but keeps every output registered.
  assign mem_valid_d = accept || (o_mem_valid && !i_mem_ready);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_valid <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_bytes <= '0;
    end else begin
      o_mem_valid <= mem_valid_d;
      if (accept) begin
        o_mem_addr  <= i_req_addr;
        o_mem_bytes <= i_req_bytes;
      end
    end
  end

  // Stall while budget is negative
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_req_ready <= 1'b0;
    end else begin
      o_req_ready <= !cred_d[`IBL_CRED_W-1] && !mem_valid_d;
    end
  end

endmodule

/* verification/ibl_limiter_sva.sv */
// Checker for the bandwidth limiter ports.
// Assumes one clock, i_rst asynchronous active high.
`timescale 1ns/100ps

module ibl_limiter_sva #(
  parameter int BYTES_W    = 8,
  parameter int REQ_ADDR_W = 32
) (
  input wire logic                  i_mclk,
  input wire logic                  i_rst,
  input wire logic                  i_awvalid,
  input wire logic                  o_awready,
  input wire logic                  i_wvalid,
  input wire logic                  o_wready,
  input wire logic                  o_bvalid,
  input wire logic                  i_bready,
  input wire logic                  i_arvalid,
  input wire logic                  o_arready,
  input wire logic                  o_rvalid,
  input wire logic                  i_rready,
  input wire logic [1:0]            o_bresp,
  input wire logic [31:0]           o_rdata,
  input wire logic                  i_req_valid,
  input wire logic                  o_req_ready,
  input wire logic                  o_mem_valid,
  input wire logic                  i_mem_ready,
  input wire logic [BYTES_W-1:0]    i_req_bytes,
  input wire logic [BYTES_W-1:0]    o_mem_bytes,
  input wire logic [REQ_ADDR_W-1:0] i_req_addr,
  input wire logic [REQ_ADDR_W-1:0] o_mem_addr
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_RD_TAKE: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
  AST_RD_HOLD: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  AST_WR_ANS: assert property (i_awvalid && o_awready && i_wvalid
    && o_wready |=> !o_awready ##1 o_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
  AST_TAKE_COPY: assert property (i_req_valid && o_req_ready |=>
    o_mem_valid && !o_req_ready && o_mem_bytes == $past(i_req_bytes))
    else $error("request not forwarded");
  AST_MEM_HOLD: assert property (o_mem_valid && !i_mem_ready |=>
    o_mem_valid && $stable(o_mem_bytes)) else $error("memory offer lost");
  AST_ADDR_COPY: assert property (i_req_valid && o_req_ready |=>
    o_mem_addr == $past(i_req_addr)) else $error("request address lost");
  AST_SLOT_STALL: assert property (o_mem_valid |-> !o_req_ready)
    else $error("taken while slot full");
  AST_MEM_DONE: assert property (o_mem_valid && i_mem_ready |=>
    !o_mem_valid) else $error("memory offer repeated");

  cover property (i_req_valid && o_req_ready);
  cover property (o_bvalid && i_bready && o_bresp == 2'h2);
  cover property (o_mem_valid && !i_mem_ready);
  // Budget stall: offer waits with the slot empty
  cover property (i_req_valid && !o_req_ready && !o_mem_valid);
endmodule

bind ibl_limiter ibl_limiter_sva #(
  .BYTES_W(BYTES_W), .REQ_ADDR_W(REQ_ADDR_W)) i_ibl_limiter_sva (
  .i_mclk, .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid,
  .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_bresp,
  .o_rdata, .i_req_valid, .o_req_ready, .o_mem_valid, .i_mem_ready,
  .i_req_bytes, .o_mem_bytes, .i_req_addr, .o_mem_addr);

/* verification/ibl_init_model.sv */
// Initiator model: fixed-size requests while i_run is high.
// Assumes the limiter's clock; payload held until taken.
`timescale 1ns/100ps

module ibl_init_model #(
  parameter int BYTES = 64
) (
  input  wire logic  i_mclk,
  input  wire logic  i_rst,
  input  wire logic  i_run,
  input  wire logic  i_ready,
  output logic       o_valid,
  output logic [31:0] o_addr,
  output logic [7:0] o_bytes
);
  // ----------------------------------------
  // Request offer
  // ----------------------------------------
  assign o_bytes = 8'(BYTES);

  // Never withdraws an offer before it is taken
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_addr  <= 32'h0;
    end else begin
      if (o_valid && i_ready) o_addr <= o_addr + 32'(BYTES);
      if (!o_valid || i_ready) o_valid <= i_run;
    end
  end
endmodule

/* verification/initiator_bandwidth_limiter_tb_top.sv */
// Testbench: register access over AXI4-Lite and burst budget runs.
// Assumes ibl_limiter, ibl_init_model and the bound checker.
`timescale 1ns/100ps
`include "ibl_params.svh"

module initiator_bandwidth_limiter_tb_top;
  import ibl_pkg::*;
  localparam int T = 100;
  logic i_mclk, i_rst, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid;
  logic i_bready, i_arvalid, o_arready, o_rvalid, i_rready, i_mem_ready;
  logic o_req_ready, o_mem_valid, i_req_valid, run;
  logic [15:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, i_req_addr, o_mem_addr;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp;
  logic [7:0]  i_req_bytes, o_mem_bytes;
  int fail_count, checked;

  ibl_limiter i_ibl_limiter (.*);
  ibl_init_model i_ibl_init_model (.i_mclk, .i_rst, .i_run(run),
    .i_ready(o_req_ready), .o_valid(i_req_valid), .o_addr(i_req_addr),
    .o_bytes(i_req_bytes));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge i_mclk);
    i_awaddr <= a; i_wdata <= d;
    i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_mclk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    i_bready <= 1'b0;
    chk({30'h0, o_bresp}, {30'h0, er});
    if (n == 50) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge i_mclk);
    i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_mclk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    i_rready <= 1'b0;
    chk(o_rdata, ed);
    chk({30'h0, o_rresp}, {30'h0, er});
    if (n == 50) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // Fill the budget to its cap, then count takes over T cycles
  task automatic burst(input int cap);
    int n, lo;
    i_mem_ready <= 1'b0; run <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_mem_ready <= 1'b1; run <= 1'b0;
    repeat (1000) @(posedge i_mclk);
    run <= 1'b1;
    n = 0;
    repeat (T) begin
      @(posedge i_mclk);
      if (i_req_valid && o_req_ready) n++;
    end
    run <= 1'b0;
    lo = (cap * 32 + 48 * T) / 2048 - 1;
    chk(32'(n >= lo && n <= lo + 4), 32'h1);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    i_mclk = 0;
    forever #20 i_mclk = ~i_mclk;
  end

  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, run} = '0;
    i_awaddr = '0; i_araddr = '0; i_wdata = '0; i_wstrb = 4'hf;
    i_mem_ready = 1'b1; fail_count = 0; checked = 0; i_rst = 1'b1;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(`IBL_OFS_FRAC, 32'h0, 2'h0);
    rd(`IBL_OFS_WHOLE, 32'h1, 2'h0);
    rd(`IBL_OFS_PEAK, 32'h7ff, 2'h0);
    wr(`IBL_OFS_FRAC, 32'hffffffff, 2'h0);
    rd(`IBL_OFS_FRAC, 32'h1f, 2'h0);
    wr(`IBL_OFS_WHOLE, 32'hffffffff, 2'h0);
    rd(`IBL_OFS_WHOLE, 32'hf, 2'h0);
    wr(`IBL_OFS_PEAK, 32'hffffffff, 2'h0);
    rd(`IBL_OFS_PEAK, 32'h7ff, 2'h0);
    wr(16'h5200, 32'h5, 2'h2);
    rd(16'h5200, 32'h0, 2'h2);
    // Only lane 1 written: peak bits 10-8 clear, low byte kept
    i_wstrb <= 4'h2;
    wr(`IBL_OFS_PEAK, 32'h0, 2'h0);
    i_wstrb <= 4'hf;
    rd(`IBL_OFS_PEAK, 32'hff, 2'h0);
    wr(`IBL_OFS_STAT, 32'h0, 2'h0);
    wr(`IBL_OFS_FRAC, 32'h30 & 32'h1f, 2'h0);
    wr(`IBL_OFS_WHOLE, 32'h30 >> 5, 2'h0);
    wr(`IBL_OFS_PEAK, 32'h0, 2'h0);
    burst(64);
    wr(`IBL_OFS_PEAK, 32'h401, 2'h0);
    burst(64 + 1024);
    repeat (1000) @(posedge i_mclk);
    // Idle budget refilled to cap (64 + 0x401 - 1) * 32, no stall
    rd(`IBL_OFS_STAT, 32'h8800, 2'h0);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    report_and_stop();
  end
endmodule
